// ---- hw/cwc_defs.svh ----
// How it works
// - Generator runs only while enable bit 7 of main control is one.
// - Load request copies both dead-band counts after falling then rising data edge.
// - Mode field picks steering, full-bridge, half-bridge or push-pull; 110/111 reserved.
// - Bit 5 of second control register reads selected data input level.
// - Each polarity flag set to one inverts its output.
// - Clock-select one picks internal fast oscillator rate, zero the system clock.
// - Input source field picks one of eight data waveforms.
// - Steering enabled output carries data waveform with its polarity.
// - Steering disabled output drives its override bit, polarity ignored.
// - Dead-band count n delays edge n-1 to n periods; zero bypasses.
// - Shutdown pair codes: 11 one, 10 zero, 01 float, 00 inactive level.
// - Shutdown is level held while an enabled source stays active.
// - Auto-restart clears shutdown; outputs resume on next data rising edge.
`ifndef CWC_DEFS_SVH
`define CWC_DEFS_SVH

`define CWC_IDX_CLK   14'h0F36
`define CWC_IDX_SRC   14'h0F37
`define CWC_IDX_RDB   14'h0F38
`define CWC_IDX_FDB   14'h0F39
`define CWC_IDX_CON0  14'h0F3A
`define CWC_IDX_CON1  14'h0F3B
`define CWC_IDX_AS0   14'h0F3C
`define CWC_IDX_AS1   14'h0F3D
`define CWC_IDX_STR   14'h0F3E
`define CWC_IDX_STAT  14'h0F40
`define CWC_IDX_MASK  14'h0F41

`define CWC_EN_BIT    7
`define CWC_LOAD_BIT  6
`define CWC_IN_BIT    5
`define CWC_SD_BIT    7
`define CWC_REN_BIT   6

`define CWC_MASK_CLK  8'h01
`define CWC_MASK_SRC  8'h07
`define CWC_MASK_DB   8'h3F
`define CWC_MASK_CON0 8'hC7
`define CWC_MASK_CON1 8'h0F
`define CWC_MASK_AS0  8'hFC
`define CWC_MASK_INT  8'h03

`define CWC_RST_AS0   8'h14
`define CWC_RST_BD    2'h1
`define CWC_RST_AC    2'h1
`define CWC_RST_ZERO  8'h00

`define CWC_MODE_ASTEER 3'h0
`define CWC_MODE_SSTEER 3'h1
`define CWC_MODE_FWD    3'h2
`define CWC_MODE_REV    3'h3
`define CWC_MODE_HALF   3'h4
`define CWC_MODE_PP     3'h5

`define CWC_SD_LOW_MASK 8'hE1
`define CWC_FAST_DIV    4'h4

`define CWC_RESP_OKAY   2'h0
`define CWC_RESP_SLVERR 2'h2

`endif

// ---- hw/cwc_pkg.sv ----
package cwc_pkg;

  typedef enum logic [1:0] {
    LOAD_IDLE,
    LOAD_ARMED,
    LOAD_FELL
  } cwc_load_t;

  typedef struct packed {
    logic [3:0] level;
    logic [3:0] oe;
  } cwc_pins_t;

  typedef struct packed {
    logic [5:0] rise;
    logic [5:0] fall;
  } cwc_db_t;

endpackage : cwc_pkg

// ---- hw/cwc_deadband.sv ----
`timescale 1ns/1ns
`default_nettype none
// Delays the rising edge of sig by count ticks; falling edge clears q on the next clock.
module cwc_deadband (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       tick,
  input  wire logic       sig,
  input  wire logic [5:0] count,
  output logic            q
);

  logic [5:0] cnt_reg;
  logic       q_reg;
  wire        done = tick & (cnt_reg == count - 6'h01);

  // Tick phase is free running, so the delay lands between n-1 and n periods
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_reg <= 6'h00;
      q_reg   <= 1'b0;
    end else if (!sig) begin
      cnt_reg <= 6'h00;
      q_reg   <= 1'b0;
    end else if (!q_reg) begin
      q_reg   <= done;
      cnt_reg <= tick ? cnt_reg + 6'h01 : cnt_reg;
    end
  end

  assign q = (count == 6'h00) ? sig : q_reg;

endmodule : cwc_deadband
`default_nettype wire

// ---- hw/cwc_top.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "cwc_defs.svh"
module cwc_top
  import cwc_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [15:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [15:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic [7:0]  data_src_in,
  input  wire logic [7:0]  shutdown_src_in,
  output var cwc_pins_t    pins_out,
  output logic             irq
);

  // ---------------- Input synchronisers ----------------
  logic [15:0] sync1_reg;
  logic [15:0] sync2_reg;
  logic [15:0] sync3_reg;
  logic [15:0] filt_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_reg <= 16'h0000;
      sync2_reg <= 16'h0000;
      sync3_reg <= 16'h0000;
    end else begin
      sync1_reg <= {shutdown_src_in, data_src_in};
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 16; gi++) begin : g_filt
      // Level only moves once two late stages agree
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          filt_reg[gi] <= 1'b0;
        end else if (sync2_reg[gi] == sync3_reg[gi]) begin
          filt_reg[gi] <= sync3_reg[gi];
        end
      end
    end
  endgenerate

  // ---------------- Registers ----------------
  logic          cs_reg;
  logic [2:0]    src_sel_reg;
  cwc_db_t       db_reg;
  cwc_db_t       db_act_reg;
  logic          en_reg;
  logic          load_req_reg;
  logic [2:0]    mode_reg;
  logic [3:0]    pol_reg;
  logic          sd_reg;
  logic          ren_reg;
  logic [1:0]    bd_code_reg;
  logic [1:0]    ac_code_reg;
  logic [7:0]    ase_reg;
  logic [7:0]    str_reg;
  logic [3:0]    str_act_reg;
  logic [1:0]    stat_reg;
  logic [1:0]    mask_reg;
  cwc_load_t     load_state_reg;
  logic          data_prev_reg;
  logic          hold_reg;
  logic          phase_reg;
  logic [3:0]    div_reg;
  logic          div_tick_reg;

  // ---------------- AXI4-Lite write path ----------------
  logic [13:0] aw_idx_reg;
  logic [7:0]  wdat_reg;
  logic        wstrb_reg;

  wire wr_fire  = !s_axi_awready & !s_axi_wready & !s_axi_bvalid;
  wire wr_ok    = wr_fire & wstrb_reg;
  wire we_clk   = wr_ok & (aw_idx_reg == `CWC_IDX_CLK);
  wire we_src   = wr_ok & (aw_idx_reg == `CWC_IDX_SRC);
  wire we_rdb   = wr_ok & (aw_idx_reg == `CWC_IDX_RDB);
  wire we_fdb   = wr_ok & (aw_idx_reg == `CWC_IDX_FDB);
  wire we_con0  = wr_ok & (aw_idx_reg == `CWC_IDX_CON0);
  wire we_con1  = wr_ok & (aw_idx_reg == `CWC_IDX_CON1);
  wire we_as0   = wr_ok & (aw_idx_reg == `CWC_IDX_AS0);
  wire we_as1   = wr_ok & (aw_idx_reg == `CWC_IDX_AS1);
  wire we_str   = wr_ok & (aw_idx_reg == `CWC_IDX_STR);
  wire we_stat  = wr_ok & (aw_idx_reg == `CWC_IDX_STAT);
  wire we_mask  = wr_ok & (aw_idx_reg == `CWC_IDX_MASK);
  wire wr_hit   = (aw_idx_reg >= `CWC_IDX_CLK) & (aw_idx_reg <= `CWC_IDX_STR)
                | (aw_idx_reg == `CWC_IDX_STAT) | (aw_idx_reg == `CWC_IDX_MASK);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `CWC_RESP_OKAY;
      aw_idx_reg    <= 14'h0000;
      wdat_reg      <= 8'h00;
      wstrb_reg     <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awready <= 1'b0;
        aw_idx_reg    <= s_axi_awaddr[15:2];
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wready <= 1'b0;
        wdat_reg     <= s_axi_wdata[7:0];
        wstrb_reg    <= s_axi_wstrb[0];
      end
      if (wr_fire) begin
        s_axi_bvalid  <= 1'b1;
        s_axi_bresp   <= wr_hit ? `CWC_RESP_OKAY : `CWC_RESP_SLVERR;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ---------------- Selected data input and edges ----------------
  wire data_lvl  = filt_reg[src_sel_reg];
  wire data_rise = data_lvl & !data_prev_reg;
  wire data_fall = !data_lvl & data_prev_reg;

  // ---------------- AXI4-Lite read path ----------------
  wire [13:0] rd_idx = s_axi_araddr[15:2];
  wire [7:0]  rv_con0 = {en_reg, load_req_reg, 3'h0, mode_reg};
  wire [7:0]  rv_con1 = {2'h0, data_lvl, 1'h0, pol_reg};
  wire [7:0]  rv_as0  = {sd_reg, ren_reg, bd_code_reg, ac_code_reg, 2'h0};
  wire        rd_hit;
  wire [7:0]  rd_val;

  // Unused bit positions are built as zeros here
  assign {rd_hit, rd_val} =
      (rd_idx == `CWC_IDX_CLK)  ? {1'b1, 7'h00, cs_reg} :
      (rd_idx == `CWC_IDX_SRC)  ? {1'b1, 5'h00, src_sel_reg} :
      (rd_idx == `CWC_IDX_RDB)  ? {1'b1, 2'h0, db_reg.rise} :
      (rd_idx == `CWC_IDX_FDB)  ? {1'b1, 2'h0, db_reg.fall} :
      (rd_idx == `CWC_IDX_CON0) ? {1'b1, rv_con0} :
      (rd_idx == `CWC_IDX_CON1) ? {1'b1, rv_con1} :
      (rd_idx == `CWC_IDX_AS0)  ? {1'b1, rv_as0} :
      (rd_idx == `CWC_IDX_AS1)  ? {1'b1, ase_reg} :
      (rd_idx == `CWC_IDX_STR)  ? {1'b1, str_reg} :
      (rd_idx == `CWC_IDX_STAT) ? {1'b1, 6'h00, stat_reg} :
      (rd_idx == `CWC_IDX_MASK) ? {1'b1, 6'h00, mask_reg} :
      9'h000;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `CWC_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= {24'h000000, rd_val};
      s_axi_rresp   <= rd_hit ? `CWC_RESP_OKAY : `CWC_RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ---------------- Plain configuration registers ----------------
  wire [7:0] wd = wdat_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cs_reg   <= 1'b0;
      src_sel_reg <= 3'h0;
      db_reg   <= '0;
      en_reg   <= 1'b0;
      mode_reg <= 3'h0;
      pol_reg  <= 4'h0;
      ren_reg  <= 1'b0;
      bd_code_reg <= `CWC_RST_BD;
      ac_code_reg <= `CWC_RST_AC;
      ase_reg  <= `CWC_RST_ZERO;
      str_reg  <= `CWC_RST_ZERO;
      mask_reg <= 2'h0;
    end else begin
      if (we_clk)  cs_reg  <= wd[0];
      if (we_src)  src_sel_reg <= wd[2:0];
      if (we_rdb)  db_reg.rise <= wd[5:0];
      if (we_fdb)  db_reg.fall <= wd[5:0];
      if (we_con0) en_reg   <= wd[`CWC_EN_BIT];
      if (we_con0) mode_reg <= wd[2:0];
      if (we_con1) pol_reg  <= wd[3:0];
      if (we_as0)  {ren_reg, bd_code_reg, ac_code_reg} <= wd[6:2];
      if (we_as1)  ase_reg  <= wd;
      if (we_str)  str_reg  <= wd;
      if (we_mask) mask_reg <= wd[1:0];
    end
  end

  // ---------------- Generator clock rate ----------------
  // Fast oscillator is modelled as an enable; it needs no system sleep clock
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_reg      <= 4'h0;
      div_tick_reg <= 1'b0;
    end else begin
      div_reg      <= (div_reg == `CWC_FAST_DIV - 4'h1) ? 4'h0 : div_reg + 4'h1;
      div_tick_reg <= (div_reg == `CWC_FAST_DIV - 4'h1);
    end
  end

  wire gen_tick = cs_reg ? div_tick_reg : 1'b1;

  // ---------------- Dead-band buffer load ----------------
  wire load_now  = (load_state_reg == LOAD_FELL) & data_rise & en_reg & load_req_reg;
  wire load_set  = we_con0 & wd[`CWC_LOAD_BIT] & en_reg;
  wire load_next = load_set | (load_req_reg & !load_now & !we_con0);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      load_req_reg   <= 1'b0;
      load_state_reg <= LOAD_IDLE;
      db_act_reg     <= '0;
    end else begin
      load_req_reg <= load_next;
      if (!en_reg) begin
        load_state_reg <= LOAD_IDLE;
        db_act_reg     <= db_reg;
      end else begin
        case (load_state_reg)
          LOAD_IDLE:  if (load_req_reg) load_state_reg <= LOAD_ARMED;
          LOAD_ARMED: if (data_fall) load_state_reg <= LOAD_FELL;
          LOAD_FELL: begin
            if (load_now) begin
              db_act_reg     <= db_reg;
            end
            if (!load_req_reg || data_rise) load_state_reg <= LOAD_IDLE;
          end
          default:    load_state_reg <= LOAD_IDLE;
        endcase
      end
    end
  end

  // ---------------- Shutdown ----------------
  wire [7:0] sd_active = filt_reg[15:8] ^ `CWC_SD_LOW_MASK;
  wire       sd_cond   = |(ase_reg & sd_active);
  wire       sd_next   = sd_cond ? 1'b1 :
                         we_as0  ? wd[`CWC_SD_BIT] :
                         ren_reg ? 1'b0 : sd_reg;
  wire       sd_event  = sd_next & !sd_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sd_reg        <= 1'b0;
      hold_reg      <= 1'b1;
      data_prev_reg <= 1'b0;
      phase_reg     <= 1'b0;
      str_act_reg   <= 4'h0;
    end else begin
      sd_reg        <= sd_next;
      data_prev_reg <= data_lvl;
      // Start-up also waits for a data rising edge
      if (sd_next) begin
        hold_reg <= 1'b1;
      end else if (data_rise && !sd_reg) begin
        hold_reg <= 1'b0;
      end
      if (data_rise) phase_reg <= !phase_reg;
      if (mode_reg != `CWC_MODE_SSTEER || data_rise) begin
        str_act_reg <= str_reg[3:0];
      end
    end
  end

  // ---------------- Interrupt ----------------
  wire [1:0] stat_set = {load_now, sd_event};
  wire [1:0] stat_clr = we_stat ? wd[1:0] : 2'h0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stat_reg <= 2'h0;
      irq      <= 1'b0;
    end else begin
      stat_reg <= (stat_reg & ~stat_clr) | stat_set;
      irq      <= |(((stat_reg & ~stat_clr) | stat_set) & mask_reg);
    end
  end

  // ---------------- Waveform ----------------
  logic rise_q;
  logic fall_q;

  cwc_deadband u_db_rise (
    .aclk    (aclk),
    .aresetn (aresetn),
    .tick    (gen_tick),
    .sig     (data_lvl),
    .count   (db_act_reg.rise),
    .q       (rise_q)
  );

  cwc_deadband u_db_fall (
    .aclk    (aclk),
    .aresetn (aresetn),
    .tick    (gen_tick),
    .sig     (!data_lvl),
    .count   (db_act_reg.fall),
    .q       (fall_q)
  );

  wire       steer   = (mode_reg == `CWC_MODE_ASTEER) | (mode_reg == `CWC_MODE_SSTEER);
  wire [3:0] str_eff = (mode_reg == `CWC_MODE_SSTEER) ? str_act_reg : str_reg[3:0];
  wire [3:0] ovr     = str_reg[7:4];
  wire [3:0] wave =
      (mode_reg == `CWC_MODE_HALF) ? {fall_q, rise_q, fall_q, rise_q} :
      (mode_reg == `CWC_MODE_PP)   ? {rise_q & !phase_reg, rise_q & phase_reg,
                                      rise_q & !phase_reg, rise_q & phase_reg} :
      (mode_reg == `CWC_MODE_FWD)  ? {rise_q, 1'b0, 1'b0, 1'b1} :
      (mode_reg == `CWC_MODE_REV)  ? {1'b0, 1'b1, rise_q, 1'b0} :
      4'h0;

  generate
    for (gi = 0; gi < 4; gi++) begin : g_out
      // Odd outputs (B, D) share one shutdown code, even ones (A, C) the other
      wire [1:0] pair_code = gi[0] ? bd_code_reg : ac_code_reg;
      wire       run_lvl   = !steer ? wave[gi] ^ pol_reg[gi] :
                             str_eff[gi] ? data_lvl ^ pol_reg[gi] :
                             ovr[gi];
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          pins_out.level[gi] <= 1'b0;
          pins_out.oe[gi]    <= 1'b0;
        end else if (hold_reg || sd_reg) begin
          pins_out.oe[gi]    <= (pair_code != 2'h1);
          pins_out.level[gi] <= pair_code[1] ? pair_code[0] : pol_reg[gi];
        end else if (!en_reg) begin
          pins_out.oe[gi]    <= 1'b0;
          pins_out.level[gi] <= 1'b0;
        end else begin
          pins_out.oe[gi]    <= 1'b1;
          pins_out.level[gi] <= run_lvl;
        end
      end
    end
  endgenerate

endmodule : cwc_top
`default_nettype wire

// ---- tb/cwc_top_props.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "cwc_defs.svh"
module cwc_top_props
  import cwc_pkg::*;
(
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire cwc_pins_t   pins_out,
  input wire logic        irq
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped early");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped early");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid && !s_axi_arready) else $error("read answer late");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |-> ##2 s_axi_bvalid) else $error("write answer late");
  a_aw_busy: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
    else $error("address ready while busy");
  a_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("upper read bits set");
  a_err_zero: assert property (s_axi_rvalid && s_axi_rresp == `CWC_RESP_SLVERR |->
    s_axi_rdata == 32'h0) else $error("error read carries data");
  a_reset_quiet: assert property ($rose(aresetn) |->
    pins_out.oe == 4'h0 && !irq && s_axi_arready) else $error("outputs active after reset");
endmodule : cwc_top_props

bind cwc_top cwc_top_props u_props (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pins_out, .irq);
`default_nettype wire

// ---- tb/cwc_stage_model.sv ----
`timescale 1ns/1ns
`default_nettype none
// Bridge driver inputs; an undriven input floats, shown as a toggling level
module cwc_stage_model
  import cwc_pkg::*;
(
  input wire logic      aclk,
  input wire cwc_pins_t pins_out,
  output logic [3:0]    node
);
  logic [3:0] last_reg = 4'h0;
  assign node = (pins_out.level & pins_out.oe) | (~last_reg & ~pins_out.oe);
  always_ff @(posedge aclk) last_reg <= node;
endmodule : cwc_stage_model
`default_nettype wire

// ---- tb/tb.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "cwc_defs.svh"
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin bad_count++; \
  $display("ERROR %s exp %0h got %0h", n, e, g); end end
module tb
  import cwc_pkg::*;
;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready, irq;
  logic [15:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, me, mg;
  logic [3:0]  s_axi_wstrb, node, p, ovr, pp;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [7:0]  data_src_in, shutdown_src_in;
  cwc_pins_t   pins_out;
  int          bad_count, samples_checked, d0, n;
  string       qn[$], mn;
  logic [31:0] qe[$];
  logic [13:0] ra[6] = '{`CWC_IDX_CLK, `CWC_IDX_SRC, `CWC_IDX_RDB, `CWC_IDX_FDB,
                         `CWC_IDX_CON1, `CWC_IDX_STR};
  logic [7:0]  rm[6] = '{8'h01, 8'h07, 8'h3F, 8'h3F, 8'h0F, 8'hFF};
  logic [7:0]  se[4] = '{8'h0F, 8'h00, 8'h0F, 8'hFF};

  cwc_top dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .data_src_in, .shutdown_src_in, .pins_out, .irq);
  cwc_stage_model u_stage (.aclk, .pins_out, .node);

  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end

  // Results leave the bus only at handshakes, so one checker serves both channels
  always @(posedge aclk) begin
    if (s_axi_rvalid && s_axi_rready || s_axi_bvalid && s_axi_bready) begin
      mn = qn.pop_front();
      me = qe.pop_front();
      mg = s_axi_rvalid ? {s_axi_rresp, s_axi_rdata[29:0]} : {s_axi_bresp, 30'h0};
      `CHK(mn, me, mg)
    end
  end

  function automatic logic [15:0] ba(input logic [13:0] i);
    return {i, 2'b00};
  endfunction : ba

  task automatic wr(input logic [13:0] a, input logic [7:0] d, input logic [1:0] r = 2'h0);
    qn.push_back("bresp");
    qe.push_back({r, 30'h0});
    @(posedge aclk);
    s_axi_awaddr <= ba(a);
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= {24'h0, d};
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready && s_axi_awvalid) s_axi_awvalid <= 1'b0;
      if (s_axi_wready && s_axi_wvalid) s_axi_wvalid <= 1'b0;
    end while (!(s_axi_bvalid && s_axi_bready));
    s_axi_bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [13:0] a, input logic [7:0] v, input string s,
                    input logic [1:0] r = 2'h0);
    qn.push_back(s);
    qe.push_back({r, 22'h0, v});
    @(posedge aclk);
    s_axi_araddr <= ba(a);
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready && s_axi_arvalid) s_axi_arvalid <= 1'b0;
    end while (!(s_axi_rvalid && s_axi_rready));
    s_axi_rready <= 1'b0;
  endtask : rd

  // Eight edges cover the input synchroniser and the output register
  task automatic dat(input logic v);
    @(posedge aclk);
    data_src_in[0] <= v;
    repeat (8) @(posedge aclk);
  endtask : dat

  task automatic pc(input logic [7:0] e);
    `CHK("pins", e, {node & pins_out.oe, pins_out.oe})
  endtask : pc

  // Edge gap from low side falling to high side rising on one data rise
  task automatic meas(output int d);
    dat(1'b0);
    @(posedge aclk);
    data_src_in[0] <= 1'b1;
    d = 0;
    while (pins_out.level[1] !== 1'b0) @(posedge aclk);
    while (pins_out.level[0] !== 1'b1) begin
      @(posedge aclk);
      d++;
    end
    repeat (4) @(posedge aclk);
  endtask : meas

  task automatic results;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : results

  initial begin
    repeat (20000) @(posedge aclk);
    bad_count++;
    results();
  end

  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, data_src_in} = '0;
    s_axi_wstrb = 4'hF;
    shutdown_src_in = `CWC_SD_LOW_MASK;
    bad_count = 0;
    samples_checked = 0;
    void'($urandom(45421));
    p = 4'($urandom);
    ovr = 4'($urandom);
    n = 1 + $urandom % 10;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`CWC_IDX_CON0, 8'h00, "con0");
    rd(`CWC_IDX_STR, 8'h00, "str");
    rd(`CWC_IDX_AS0, `CWC_RST_AS0, "as0");
    rd(`CWC_IDX_CON1, 8'h00, "con1");
    rd(14'h0F44, 8'h00, "hole", `CWC_RESP_SLVERR);
    wr(14'h0F44, 8'hFF, `CWC_RESP_SLVERR);
    $display("test reset done");
    for (int i = 0; i < 6; i++) begin
      wr(ra[i], 8'hFF);
      rd(ra[i], rm[i], "mask");
      wr(ra[i], 8'h00);
    end
    $display("test bits done");
    for (int i = 0; i < 8; i++) begin
      wr(`CWC_IDX_SRC, 8'(i));
      data_src_in <= 8'h01 << i;
      repeat (6) @(posedge aclk);
      rd(`CWC_IDX_CON1, 8'h20, "in_hi");
      data_src_in <= ~(8'h01 << i);
      repeat (6) @(posedge aclk);
      rd(`CWC_IDX_CON1, 8'h00, "in_lo");
    end
    wr(`CWC_IDX_SRC, 8'h00);
    data_src_in <= 8'h00;
    $display("test source done");
    wr(`CWC_IDX_CON1, {4'h0, p});
    wr(`CWC_IDX_STR, {ovr, 4'h0});
    wr(`CWC_IDX_CON0, 8'h80);
    dat(1'b1);
    dat(1'b0);
    dat(1'b1);
    pc({ovr, 4'hF});
    wr(`CWC_IDX_STR, {ovr, 4'hF});
    dat(1'b1);
    pc({~p, 4'hF});
    dat(1'b0);
    pc({p, 4'hF});
    wr(`CWC_IDX_CON0, 8'h81);
    wr(`CWC_IDX_STR, {ovr, 4'h0});
    pc({p, 4'hF});
    dat(1'b1);
    pc({ovr, 4'hF});
    wr(`CWC_IDX_CON0, 8'h00);
    @(posedge aclk);
    pc(8'h00);
    $display("test steering done");
    wr(`CWC_IDX_CON1, 8'h00);
    wr(`CWC_IDX_RDB, 8'(n));
    wr(`CWC_IDX_FDB, 8'h00);
    wr(`CWC_IDX_CON0, 8'h84);
    dat(1'b1);
    meas(d0);
    `CHK("db_n", 1'b1, d0 >= n && d0 <= n + 1)
    wr(`CWC_IDX_RDB, 8'h00);
    meas(d0);
    `CHK("db_keep", 1'b1, d0 >= n && d0 <= n + 1)
    wr(`CWC_IDX_STAT, 8'h03);
    wr(`CWC_IDX_MASK, 8'h00);
    wr(`CWC_IDX_CON0, 8'hC4);
    meas(d0);
    meas(d0);
    `CHK("db_zero", 1'b1, d0 <= 1)
    `CHK("irq_mask", 1'b0, irq)
    rd(`CWC_IDX_CON0, 8'h84, "load_clr");
    rd(`CWC_IDX_STAT, 8'h02, "stat");
    wr(`CWC_IDX_MASK, 8'h02);
    repeat (2) @(posedge aclk);
    `CHK("irq_on", 1'b1, irq)
    wr(`CWC_IDX_STAT, 8'h02);
    repeat (2) @(posedge aclk);
    `CHK("irq_off", 1'b0, irq)
    wr(`CWC_IDX_CON0, 8'h82);
    @(posedge aclk);
    pc(8'h9F);
    wr(`CWC_IDX_CON0, 8'h83);
    @(posedge aclk);
    pc(8'h6F);
    wr(`CWC_IDX_CON0, 8'h85);
    dat(1'b0);
    pc(8'h0F);
    dat(1'b1);
    pp = pins_out.level;
    dat(1'b0);
    dat(1'b1);
    `CHK("push_pull", 1'b1, (pp == 4'h5 || pp == 4'hA) && pins_out.level == ~pp)
    $display("test deadband done");
    wr(`CWC_IDX_CON0, 8'h80);
    wr(`CWC_IDX_AS1, 8'h02);
    wr(`CWC_IDX_MASK, 8'h01);
    shutdown_src_in[1] <= 1'b1;
    repeat (6) @(posedge aclk);
    `CHK("irq_sd", 1'b1, irq)
    for (int c = 0; c < 4; c++) begin
      wr(`CWC_IDX_AS0, 8'(c * 20));
      repeat (2) @(posedge aclk);
      pc(se[c]);
    end
    rd(`CWC_IDX_AS0, 8'hBC, "sd_held");
    wr(`CWC_IDX_STAT, 8'h01);
    repeat (2) @(posedge aclk);
    `CHK("irq_clr", 1'b0, irq)
    shutdown_src_in[1] <= 1'b0;
    repeat (6) @(posedge aclk);
    pc(8'hFF);
    wr(`CWC_IDX_AS0, 8'h3C);
    rd(`CWC_IDX_AS0, 8'h3C, "sd_clr");
    dat(1'b0);
    pc(8'hFF);
    dat(1'b1);
    pc({ovr, 4'hF});
    wr(`CWC_IDX_AS0, 8'h7C);
    shutdown_src_in[1] <= 1'b1;
    repeat (6) @(posedge aclk);
    rd(`CWC_IDX_AS0, 8'hFC, "sd_auto_on");
    shutdown_src_in[1] <= 1'b0;
    repeat (6) @(posedge aclk);
    rd(`CWC_IDX_AS0, 8'h7C, "sd_auto");
    $display("test shutdown done");
    results();
  end
endmodule : tb
`default_nettype wire
